// >>> inc/cra_regs.svh
// Constants of the configuration access link: token codes, address patterns,
// bank numbers and message lengths.
// Assumes it is included by bare name by the package and by design files.
`ifndef CRA_REGS_SVH
`define CRA_REGS_SVH

// ****************************************************************
// Control token codes
// ****************************************************************
`define CRA_TOK_WRITE 8'hc0
`define CRA_TOK_READ 8'hc1
`define CRA_TOK_PWRITE 8'h24
`define CRA_TOK_PREAD 8'h25
`define CRA_TOK_END 8'h01
`define CRA_TOK_ACK 8'h03
`define CRA_TOK_NACK 8'h04

// ****************************************************************
// Destination patterns
// ****************************************************************
`define CRA_TILE_LOW 16'hc20c
`define CRA_NODE_LOW 16'hc30c
`define CRA_RES_LOW 8'h0c
`define CRA_PERIPH_COUNT 8'h07

// ****************************************************************
// Banks: status, tile, node, then seven peripherals
// ****************************************************************
`define CRA_BANK_PS 4'h0
`define CRA_BANK_TILE 4'h1
`define CRA_BANK_NODE 4'h2
`define CRA_BANK_PERIPH 4'h3
`define CRA_BANK_NONE 4'hf

// ****************************************************************
// Message lengths in bytes, between the opening and closing tokens
// ****************************************************************
`define CRA_REPLY_BYTES 9'h003
`define CRA_REG_END 9'h005
`define CRA_PSIZE_POS 9'h004
`define CRA_HDR_BYTES 9'h005
`define CRA_WORD_BYTES 9'h004
`define CRA_MAX_SIZE 8'h04
`define CRA_FIFO_DEPTH 8

`endif

// >>> inc/cra_pkg.sv
// Types and shared helpers of the configuration access link.
// Assumes cra_regs.svh is on the include path.
package cra_pkg;
  `include "cra_regs.svh"

  // Target of a host command
  typedef enum logic [1:0] {CRA_TGT_TILE, CRA_TGT_NODE, CRA_TGT_PERIPH} cra_target_e;

  // Responder states
  typedef enum logic [2:0] {
    DS_IDLE, DS_BODY, DS_ACCESS, DS_PSDONE, DS_HEAD, DS_DATA, DS_TAIL
  } cra_dev_state_e;

  // Requester states
  typedef enum logic [2:0] {HS_IDLE, HS_OPEN, HS_BODY, HS_END, HS_WAIT, HS_DONE} cra_host_state_e;

  // Responder state
  typedef struct packed {
    cra_dev_state_e st;
    logic wr;
    logic per;
    logic ps;
    logic bad;
    logic ok;
    logic [3:0] bank;
    logic [8:0] cnt;
    logic [2:0] left;
    logic [23:0] reply;
    logic [15:0] regn;
    logic [7:0] size;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } cra_dev_s;

  // Requester state
  typedef struct packed {
    cra_host_state_e st;
    logic [7:0] op;
    logic [31:0] dest;
    logic [71:0] bytes;
    logic [8:0] cnt;
    logic ok;
    logic [31:0] rdata;
    logic [15:0] res_id;
  } cra_host_s;

  // Moves the low n bytes of a word to its top, so they leave MSB first
  function automatic logic [31:0] cra_align(input logic [31:0] w, input logic [7:0] n);
    case (n)
      8'h01: cra_align = {w[7:0], 24'h000000};
      8'h02: cra_align = {w[15:0], 16'h0000};
      8'h03: cra_align = {w[23:0], 8'h00};
      default: cra_align = w;
    endcase
  endfunction

  // Bank reached through a channel-end destination
  function automatic logic [3:0] cra_bank(input logic [31:0] d);
    if (d[15:0] == `CRA_TILE_LOW) begin
      cra_bank = `CRA_BANK_TILE;
    end else if (d[15:0] == `CRA_NODE_LOW) begin
      cra_bank = `CRA_BANK_NODE;
    end else if (d[7:0] == `CRA_RES_LOW && d[15:8] < `CRA_PERIPH_COUNT) begin
      cra_bank = `CRA_BANK_PERIPH + d[11:8];
    end else begin
      cra_bank = `CRA_BANK_NONE;
    end
  endfunction
endpackage

// >>> inc/cra_link_if.sv
// Token link between requester and responder: a request token stream with
// its channel-end destination, and a reply token stream with its reply id.
// Assumes both ends share clock and reset; the bench joins them.
`timescale 1ns/1ps
interface cra_link_if;
  logic req_valid; // Request token present
  logic req_ctrl; // Token is a control token
  logic [7:0] req_data; // Token value
  logic req_ready; // Responder takes the token
  logic [31:0] req_dest; // Destination of the channel end
  logic rsp_valid; // Reply token present
  logic rsp_ctrl; // Reply token is a control token
  logic [7:0] rsp_data; // Reply token value
  logic rsp_ready; // Requester takes the reply token
  logic [23:0] rsp_dest; // Reply channel-end identifier

  modport dev (
    input req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
  modport host (
    output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
endinterface

// >>> hw/cra_device.sv
// Configuration access responder with its request token FIFO.
// Assumes one clock, synchronous reset, and a register back end that answers
// each access with a one-cycle acknowledge.
`timescale 1ns/1ps
`include "cra_regs.svh"

// ****************************************************************
// Token FIFO
// ****************************************************************
module cra_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `CRA_FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // Whole FIFO state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } cra_fifo_s;

  cra_fifo_s s;
  cra_fifo_s next_s;
  logic push; // Word written this cycle
  logic pop; // Word read this cycle

  // Full and empty come straight from the count, so both stay honest
  assign in_ready_o = s.count != (AW + 1)'(DEPTH);
  assign out_valid_o = s.count != '0;
  assign out_data_o = s.mem[s.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    next_s.count = s.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ****************************************************************
// Responder
// ****************************************************************
module cra_device (
  input wire logic clock_i,
  input wire logic reset_i,
  cra_link_if.dev link,
  input wire logic ps_valid_i, // Status register instruction
  output logic ps_ready_o,
  input wire logic ps_write_i,
  input wire logic [7:0] ps_reg_i,
  input wire logic [31:0] ps_wdata_i,
  output logic ps_done_o,
  output logic ps_ok_o,
  output logic [31:0] ps_rdata_o,
  output logic reg_valid_o, // Register access held until acknowledge
  output logic [3:0] reg_bank_o,
  output logic reg_write_o,
  output logic [15:0] reg_addr_o,
  output logic [7:0] reg_size_o,
  output logic [31:0] reg_wdata_o,
  input wire logic reg_ack_i,
  input wire logic reg_ok_i,
  input wire logic [31:0] reg_rdata_i
);
  import cra_pkg::*;

  cra_dev_s s; // All responder state
  cra_dev_s next_s;
  logic f_valid; // FIFO head present
  logic f_ready; // Parser takes FIFO head
  logic [8:0] f_word; // {ctrl, value}
  logic [7:0] b; // FIFO head value
  logic [8:0] need; // Bytes the message must carry
  logic [3:0] dbank; // Bank of the current destination

  // The FIFO absorbs bursts while an access or reply is pending; its
  // ready is the link ready, so a slow back end stalls the requester.
  cra_fifo #(.WIDTH(9), .DEPTH(`CRA_FIFO_DEPTH)) cra_fifo_i (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(link.req_valid),
    .in_ready_o(link.req_ready),
    .in_data_i({link.req_ctrl, link.req_data}),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_word)
  );

  assign b = f_word[7:0];
  assign dbank = cra_bank(link.req_dest);

  // Expected length: word formats are fixed, peripheral writes carry size
  always_comb begin
    if (s.per) begin
      need = s.wr ? `CRA_HDR_BYTES + {1'b0, s.size} : `CRA_HDR_BYTES;
    end else begin
      need = s.wr ? `CRA_HDR_BYTES + `CRA_WORD_BYTES : `CRA_HDR_BYTES;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ps_ready_o = s.st == DS_IDLE;
  assign ps_done_o = s.st == DS_PSDONE;
  assign ps_ok_o = s.ok;
  assign ps_rdata_o = s.rdata;
  assign reg_valid_o = s.st == DS_ACCESS;
  assign reg_bank_o = s.bank;
  assign reg_write_o = s.wr;
  assign reg_addr_o = s.regn;
  assign reg_size_o = s.size;
  assign reg_wdata_o = s.wdata;
  assign link.rsp_dest = s.reply;

  // Reply stream: head token, data bytes MSB first, closing token
  always_comb begin
    link.rsp_valid = 1'b0;
    link.rsp_ctrl = 1'b1;
    link.rsp_data = `CRA_TOK_END;
    case (s.st)
      DS_HEAD: begin
        link.rsp_valid = 1'b1;
        link.rsp_data = s.ok ? `CRA_TOK_ACK : `CRA_TOK_NACK;
      end
      DS_DATA: begin
        link.rsp_valid = 1'b1;
        link.rsp_ctrl = 1'b0;
        link.rsp_data = s.rdata[31:24];
      end
      DS_TAIL: begin
        link.rsp_valid = 1'b1;
      end
      default: begin
        link.rsp_valid = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Parser and sequencer
  // ****************************************************************
  always_comb begin
    next_s = s;
    f_ready = 1'b0;
    case (s.st)
      DS_IDLE: begin
        if (ps_valid_i) begin
          // Status word goes straight to bank zero, no message
          next_s.ps = 1'b1;
          next_s.bank = `CRA_BANK_PS;
          next_s.wr = ps_write_i;
          next_s.per = 1'b0;
          next_s.regn = {8'h00, ps_reg_i};
          next_s.size = `CRA_MAX_SIZE;
          next_s.wdata = ps_wdata_i;
          next_s.st = DS_ACCESS;
        end else if (f_valid) begin
          f_ready = 1'b1;
          // Stray data between messages is dropped
          if (f_word[8]) begin
            next_s.ps = 1'b0;
            next_s.per = b == `CRA_TOK_PWRITE || b == `CRA_TOK_PREAD;
            next_s.wr = b == `CRA_TOK_WRITE || b == `CRA_TOK_PWRITE;
            next_s.bad = !(b == `CRA_TOK_WRITE || b == `CRA_TOK_READ ||
                           b == `CRA_TOK_PWRITE || b == `CRA_TOK_PREAD) ||
                         dbank == `CRA_BANK_NONE;
            next_s.bank = dbank;
            next_s.cnt = '0;
            next_s.regn = '0;
            next_s.size = `CRA_MAX_SIZE;
            next_s.wdata = '0;
            next_s.st = DS_BODY;
          end
        end
      end
      DS_BODY: begin
        if (f_valid) begin
          f_ready = 1'b1;
          if (f_word[8]) begin
            if (b == `CRA_TOK_END) begin
              // Nothing is touched before the closing token
              if (s.bad || s.cnt != need || s.size > `CRA_MAX_SIZE ||
                  s.per != (s.bank >= `CRA_BANK_PERIPH)) begin
                next_s.ok = 1'b0;
                next_s.left = '0;
                next_s.st = DS_HEAD;
              end else begin
                next_s.st = DS_ACCESS;
              end
            end else begin
              next_s.bad = 1'b1;
            end
          end else begin
            if (s.cnt < `CRA_REPLY_BYTES) begin
              next_s.reply = {s.reply[15:0], b};
            end else if ((!s.per && s.cnt < `CRA_REG_END) || (s.per && s.cnt == `CRA_REPLY_BYTES)) begin
              next_s.regn = {s.regn[7:0], b};
            end else if (s.per && s.cnt == `CRA_PSIZE_POS) begin
              next_s.size = b;
            end else begin
              next_s.wdata = {s.wdata[23:0], b};
            end
            // Saturate so an overlong message still fails the length check
            if (s.cnt != 9'h1ff) begin
              next_s.cnt = s.cnt + 9'h001;
            end
          end
        end
      end
      DS_ACCESS: begin
        if (reg_ack_i) begin
          next_s.ok = reg_ok_i;
          next_s.rdata = s.per ? cra_align(reg_rdata_i, s.size) : reg_rdata_i;
          if (!s.wr && reg_ok_i) begin
            next_s.left = s.per ? s.size[2:0] : 3'(`CRA_WORD_BYTES);
          end else begin
            next_s.left = '0;
          end
          next_s.st = s.ps ? DS_PSDONE : DS_HEAD;
        end
      end
      DS_PSDONE: begin
        next_s.ps = 1'b0;
        next_s.st = DS_IDLE;
      end
      DS_HEAD: begin
        if (link.rsp_ready) begin
          next_s.st = (s.left != '0) ? DS_DATA : DS_TAIL;
        end
      end
      DS_DATA: begin
        if (link.rsp_ready) begin
          next_s.rdata = {s.rdata[23:0], 8'h00};
          next_s.left = s.left - 3'h1;
          if (s.left == 3'h1) begin
            next_s.st = DS_TAIL;
          end
        end
      end
      DS_TAIL: begin
        if (link.rsp_ready) begin
          next_s.st = DS_IDLE;
        end
      end
      default: begin
        next_s.st = DS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// >>> hw/cra_host.sv
// Configuration access requester: builds request messages from user
// commands and collects the reply.
// Assumes the responder sits on the other side of cra_link_if.
`timescale 1ns/1ps
`include "cra_regs.svh"
module cra_host (
  input wire logic clock_i,
  input wire logic reset_i,
  cra_link_if.host link,
  input wire logic cmd_valid_i, // Command offered
  output logic cmd_ready_o,
  input wire cra_pkg::cra_target_e cmd_target_i,
  input wire logic cmd_write_i,
  input wire logic [15:0] cmd_id_i, // Tile or node identifier
  input wire logic [7:0] cmd_periph_i,
  input wire logic [15:0] cmd_reg_i,
  input wire logic [7:0] cmd_size_i,
  input wire logic [31:0] cmd_wdata_i,
  input wire logic [23:0] cmd_reply_i,
  output logic res_valid_o, // One-cycle result pulse
  output logic res_ok_o,
  output logic [31:0] res_rdata_o,
  input wire logic [7:0] ps_reg_i,
  output logic [15:0] ps_res_id_o
);
  import cra_pkg::*;

  cra_host_s s; // All requester state
  cra_host_s next_s;
  logic per; // Command targets a peripheral

  assign per = cmd_target_i == CRA_TGT_PERIPH;
  assign cmd_ready_o = s.st == HS_IDLE;
  assign res_valid_o = s.st == HS_DONE;
  assign res_ok_o = s.ok;
  assign res_rdata_o = s.rdata;
  assign ps_res_id_o = s.res_id;
  assign link.req_dest = s.dest;
  assign link.rsp_ready = s.st == HS_WAIT;

  // ****************************************************************
  // Request stream
  // ****************************************************************
  always_comb begin
    link.req_valid = 1'b1;
    link.req_ctrl = 1'b1;
    link.req_data = `CRA_TOK_END;
    case (s.st)
      HS_OPEN: link.req_data = s.op;
      HS_BODY: begin
        link.req_ctrl = 1'b0;
        link.req_data = s.bytes[71:64];
      end
      HS_END: link.req_data = `CRA_TOK_END;
      default: link.req_valid = 1'b0;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.res_id = {ps_reg_i, `CRA_RES_LOW};
    case (s.st)
      HS_IDLE: begin
        if (cmd_valid_i) begin
          case (cmd_target_i)
            CRA_TGT_TILE: next_s.dest = {cmd_id_i, `CRA_TILE_LOW};
            CRA_TGT_NODE: next_s.dest = {cmd_id_i, `CRA_NODE_LOW};
            default: next_s.dest = {cmd_id_i, cmd_periph_i, `CRA_RES_LOW};
          endcase
          if (per) begin
            next_s.op = cmd_write_i ? `CRA_TOK_PWRITE : `CRA_TOK_PREAD;
            next_s.bytes = {cmd_reply_i, cmd_reg_i[7:0], cmd_size_i,
                            cra_align(cmd_wdata_i, cmd_size_i)};
            next_s.cnt = cmd_write_i ? `CRA_HDR_BYTES + {1'b0, cmd_size_i} : `CRA_HDR_BYTES;
          end else begin
            next_s.op = cmd_write_i ? `CRA_TOK_WRITE : `CRA_TOK_READ;
            next_s.bytes = {cmd_reply_i, cmd_reg_i, cmd_wdata_i};
            next_s.cnt = cmd_write_i ? `CRA_HDR_BYTES + `CRA_WORD_BYTES : `CRA_HDR_BYTES;
          end
          next_s.ok = 1'b0;
          next_s.rdata = '0;
          next_s.st = HS_OPEN;
        end
      end
      HS_OPEN: begin
        if (link.req_ready) begin
          next_s.st = HS_BODY;
        end
      end
      HS_BODY: begin
        // Bytes past the fourth data byte go out as zero
        if (link.req_ready) begin
          next_s.bytes = {s.bytes[63:0], 8'h00};
          next_s.cnt = s.cnt - 9'h001;
          if (s.cnt == 9'h001) begin
            next_s.st = HS_END;
          end
        end
      end
      HS_END: begin
        if (link.req_ready) begin
          next_s.st = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (link.rsp_valid) begin
          if (!link.rsp_ctrl) begin
            next_s.rdata = {s.rdata[23:0], link.rsp_data};
          end else if (link.rsp_data == `CRA_TOK_ACK) begin
            next_s.ok = 1'b1;
          end else if (link.rsp_data == `CRA_TOK_NACK) begin
            next_s.ok = 1'b0;
          end else if (link.rsp_data == `CRA_TOK_END) begin
            next_s.st = HS_DONE;
          end
        end
      end
      HS_DONE: next_s.st = HS_IDLE;
      default: next_s.st = HS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// >>> verification/cra_link_checker.sv
// Concurrent checks on the token link between requester and responder.
// Assumes it sees the link signals plus the shared clock and reset.
`timescale 1ns/1ps
`include "cra_regs.svh"

// ****************************************************************
// Link checker
// ****************************************************************
module cra_link_checker (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic req_valid,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic req_ready,
  input wire logic [31:0] req_dest,
  input wire logic rsp_valid,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_ready
);
  import cra_pkg::*;
  // One clock domain, so one clocking and one disable for all checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  // Closing token of a request handed over
  sequence s_close_taken;
    req_valid && req_ready && req_ctrl && req_data == `CRA_TOK_END;
  endsequence
  // Failure token of a reply handed over
  sequence s_nack_taken;
    rsp_valid && rsp_ready && rsp_ctrl && rsp_data == `CRA_TOK_NACK;
  endsequence
  // Closing token of a reply
  sequence s_reply_end;
    rsp_valid && rsp_ctrl && rsp_data == `CRA_TOK_END;
  endsequence

  chk_reply_after_close: assert property (s_close_taken |-> ##[3:60] rsp_valid)
    else $error("no reply after a closing token");
  chk_nack_then_end: assert property (s_nack_taken |=> ##[0:3] s_reply_end)
    else $error("failure token not followed by closing token");
  chk_reply_codes: assert property (rsp_valid && rsp_ctrl |->
      rsp_data inside {`CRA_TOK_ACK, `CRA_TOK_NACK, `CRA_TOK_END})
    else $error("unknown reply control token");
  chk_reply_ends: assert property (s_reply_end and rsp_ready |=> !rsp_valid)
    else $error("reply goes on after its closing token");
  chk_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_data) && $stable(rsp_ctrl))
    else $error("reply token changed before taken");
  chk_word_dest: assert property (req_valid && req_ctrl &&
      req_data inside {`CRA_TOK_WRITE, `CRA_TOK_READ} |->
      req_dest[15:0] inside {`CRA_TILE_LOW, `CRA_NODE_LOW})
    else $error("word request to a wrong destination");
  chk_periph_dest: assert property (req_valid && req_ctrl &&
      req_data inside {`CRA_TOK_PWRITE, `CRA_TOK_PREAD} |->
      req_dest[7:0] == `CRA_RES_LOW && req_dest[15:8] < `CRA_PERIPH_COUNT)
    else $error("peripheral request to a wrong destination");
  chk_dest_stable: assert property (req_valid &&
      !(req_ctrl && req_data == `CRA_TOK_END) |=> $stable(req_dest))
    else $error("destination changed inside a message");
endmodule

// >>> verification/test_config_register_message_access.sv
// Bench joining requester and responder; a small back end answers accesses.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
`include "cra_regs.svh"
module test_config_register_message_access;
  import cra_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_valid = 1'b0; // Command strobe to the requester
  logic cmd_ready, cmd_write = 1'b0, res_valid, res_ok, ps_valid = 1'b0, ps_write = 1'b0;
  cra_target_e cmd_target = CRA_TGT_TILE;
  logic [15:0] cmd_reg = 16'h0000, ps_res_id, reg_addr;
  logic [7:0] cmd_periph = 8'h00, cmd_size = 8'h00, ps_reg = 8'h00, reg_size;
  logic [31:0] cmd_wdata = 32'h0, res_rdata, ps_wdata = 32'h0, ps_rdata, reg_wdata;
  logic ps_ready, ps_done, ps_ok, reg_valid, reg_write, reg_ack = 1'b0;
  logic [3:0] reg_bank;
  logic bk_ok = 1'b1; // Back end answer and last access seen
  logic [31:0] bk_rdata = 32'h0, bk_wd;
  logic [3:0] bk_bank;
  logic [15:0] bk_addr;
  logic [7:0] bk_size;
  logic bk_wr;
  int bk_count = 0, miscompares = 0, check_count = 0, cycles = 0;

  cra_link_if link();
  cra_device cra_device_i (.clock_i(clock_i), .reset_i(reset_i), .link(link),
    .ps_valid_i(ps_valid), .ps_ready_o(ps_ready), .ps_write_i(ps_write), .ps_reg_i(ps_reg),
    .ps_wdata_i(ps_wdata), .ps_done_o(ps_done), .ps_ok_o(ps_ok), .ps_rdata_o(ps_rdata),
    .reg_valid_o(reg_valid), .reg_bank_o(reg_bank), .reg_write_o(reg_write),
    .reg_addr_o(reg_addr), .reg_size_o(reg_size), .reg_wdata_o(reg_wdata),
    .reg_ack_i(reg_ack), .reg_ok_i(bk_ok), .reg_rdata_i(bk_rdata));
  cra_host cra_host_i (.clock_i(clock_i), .reset_i(reset_i), .link(link),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_target_i(cmd_target),
    .cmd_write_i(cmd_write), .cmd_id_i(16'h0a5c), .cmd_periph_i(cmd_periph),
    .cmd_reg_i(cmd_reg), .cmd_size_i(cmd_size), .cmd_wdata_i(cmd_wdata),
    .cmd_reply_i(24'h3c0d12), .res_valid_o(res_valid), .res_ok_o(res_ok),
    .res_rdata_o(res_rdata), .ps_reg_i(ps_reg), .ps_res_id_o(ps_res_id));
  cra_link_checker cra_link_checker_i (.clock_i(clock_i), .reset_i(reset_i),
    .req_valid(link.req_valid), .req_ctrl(link.req_ctrl), .req_data(link.req_data),
    .req_ready(link.req_ready), .req_dest(link.req_dest), .rsp_valid(link.rsp_valid),
    .rsp_ctrl(link.rsp_ctrl), .rsp_data(link.rsp_data), .rsp_ready(link.rsp_ready));

  // ****************************************************************
  // Clock, back end and hang guard
  // ****************************************************************
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  // Back end acknowledges each access half a cycle after it shows, records it
  always @(negedge clock_i) begin
    if (reg_valid && !reg_ack) begin
      reg_ack <= 1'b1;
      {bk_bank, bk_addr, bk_wr, bk_size, bk_wd} <= {reg_bank, reg_addr, reg_write,
        reg_size, reg_wdata};
      bk_count <= bk_count + 1;
    end else begin
      reg_ack <= 1'b0;
    end
  end
  // Whole run needs well under a thousand cycles; far above that means a hang
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One command through the link; bank NONE means no access may happen
  task automatic run(input cra_target_e tg, input logic wr, input logic [7:0] per,
      input logic [15:0] rg, input logic [7:0] sz, input logic [31:0] wd, input logic ok,
      input logic [31:0] rd, input logic [31:0] exp_rd, input logic [3:0] exp_bank);
    int n;
    logic per_path;
    n = bk_count;
    per_path = (tg == CRA_TGT_PERIPH);
    @(negedge clock_i);
    while (cmd_ready !== 1'b1) @(negedge clock_i);
    {cmd_target, cmd_write, cmd_periph, cmd_reg, cmd_size, cmd_wdata} = {tg, wr, per, rg,
      sz, wd};
    {bk_ok, bk_rdata} = {ok, rd};
    cmd_valid = 1'b1;
    @(negedge clock_i);
    cmd_valid = 1'b0;
    for (int i = 0; i < 300 && res_valid !== 1'b1; i++) @(negedge clock_i);
    check("res_valid", res_valid, 1'b1);
    check("res_ok", res_ok, ok && exp_bank != `CRA_BANK_NONE);
    if (!wr) check("res_rdata", res_rdata, exp_rd);
    check("access_count", bk_count - n, exp_bank != `CRA_BANK_NONE);
    check("rsp_dest", link.rsp_dest, 24'h3c0d12);
    check("dest_id", link.req_dest[31:16], 16'h0a5c);
    if (per_path) check("dest_periph", link.req_dest[15:8], per);
    if (exp_bank != `CRA_BANK_NONE) begin
      check("bank", bk_bank, exp_bank);
      check("addr", bk_addr, per_path ? {8'h00, rg[7:0]} : rg);
      check("write", bk_wr, wr);
      check("size", bk_size, per_path ? sz : 8'h04);
      if (wr) check("wdata", bk_wd, wd);
    end
    $display("test target %0d write %0d size %0d done", tg, wr, sz);
  endtask

  // One status register instruction, with no message on the link
  task automatic ps_op(input logic wr, input logic [7:0] rg, input logic [31:0] v);
    @(negedge clock_i);
    while (ps_ready !== 1'b1) @(negedge clock_i);
    {ps_valid, ps_write, ps_reg, ps_wdata, bk_ok, bk_rdata} = {1'b1, wr, rg, v, 1'b1, v};
    @(negedge clock_i);
    ps_valid = 1'b0;
    for (int i = 0; i < 50 && ps_done !== 1'b1; i++) @(negedge clock_i);
    check("ps_ok", ps_ok, 1'b1);
    if (!wr) check("ps_rdata", ps_rdata, v);
    check("ps_bank", {bk_bank, bk_addr, bk_wr}, {4'h0, 8'h00, rg, wr});
    check("ps_res_id", ps_res_id, {rg, 8'h0c});
    $display("test status write %0d done", wr);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (5) @(negedge clock_i);
    reset_i = 1'b0;
    check("idle_ready", {cmd_ready, ps_ready, res_valid, reg_valid}, 4'hc);
    run(CRA_TGT_TILE, 1, 0, 16'h0123, 4, 32'hdeadbeef, 1, 0, 0, `CRA_BANK_TILE);
    run(CRA_TGT_NODE, 0, 0, 16'hfe01, 4, 0, 1, 32'h89abcdef, 32'h89abcdef,
      `CRA_BANK_NODE);
    run(CRA_TGT_NODE, 1, 0, 16'h0002, 4, 32'h1, 0, 0, 0, `CRA_BANK_NODE);
    run(CRA_TGT_TILE, 0, 0, 16'hffff, 4, 0, 0, 32'h55aa55aa, 0, `CRA_BANK_TILE);
    for (int p = 0; p < 7; p++) begin
      run(CRA_TGT_PERIPH, 1, p[7:0], 16'h0010, 1, 32'h5a, 1, 0, 0,
        `CRA_BANK_PERIPH + p[3:0]);
      run(CRA_TGT_PERIPH, 0, p[7:0], 16'h00f1, 2, 0, 1, 32'h1234abcd, 32'habcd,
        `CRA_BANK_PERIPH + p[3:0]);
    end
    run(CRA_TGT_PERIPH, 1, 1, 16'h0020, 4, 32'hcafe0123, 1, 0, 0,
      `CRA_BANK_PERIPH + 4'h1);
    run(CRA_TGT_PERIPH, 0, 2, 16'h0021, 4, 0, 1, 32'h0badf00d, 32'h0badf00d,
      4'h5);
    run(CRA_TGT_PERIPH, 1, 0, 16'h0022, 5, 32'h77, 1, 0, 0, `CRA_BANK_NONE);
    ps_op(1, 8'h06, 32'h00000003);
    ps_op(0, 8'h3a, 32'h00010000);
    final_report();
  end
endmodule
